// *** hw/flash_op_map.vh ***
// register offsets, field positions, codes and timing for the flash operation control block
`ifndef FLASH_OP_MAP_VH
`define FLASH_OP_MAP_VH

// ************************************
// register byte offsets
// ************************************
`define FOC_CTRL_OFS        12'h000
`define FOC_STAT_OFS        12'h004
`define FOC_ADDR_OFS        12'h008

// ************************************
// control register fields
// ************************************
`define FOC_START_BIT       15
`define FOC_ENABLE_BIT      14
`define FOC_ERROR_BIT       13
`define FOC_IDLE_SB_BIT     12
`define FOC_OPSEL_HI        3
`define FOC_OPSEL_LO        0
`define FOC_CTRL_RESET      16'h0000

// ************************************
// operation select codes
// ************************************
`define FOC_OP_PAGE_ERASE   4'h3
`define FOC_OP_DWORD_PROG   4'h1

// ************************************
// timing, 10 mhz clock
// ************************************
`define FOC_CLK_MHZ         10
`define FOC_ERASE_US        20000
`define FOC_PROG_US         50
`define FOC_WAKE_US         30
`define FOC_ERASE_CYC       (`FOC_ERASE_US * `FOC_CLK_MHZ)
`define FOC_PROG_CYC        (`FOC_PROG_US * `FOC_CLK_MHZ)
`define FOC_WAKE_CYC        (`FOC_WAKE_US * `FOC_CLK_MHZ)

`endif

// *** hw/op_timer.v ***
// down counter that times one self-timed flash step
`timescale 1ns/1ps
module op_timer #(
  parameter WIDTH = 24
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             sys_rst,
  // control
  input  wire             load,
  input  wire [WIDTH-1:0] count,
  // status
  output wire             busy,
  output wire             done
);

  reg [WIDTH-1:0] cnt_q;  // remaining cycles
  reg             run_q;  // timer active
  reg             done_q; // one-cycle end pulse

  // ************************************
  // countdown
  // ************************************
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q  <= {WIDTH{1'b0}};
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load) begin
        // zero count still takes one cycle
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign busy = run_q;
  assign done = done_q;

endmodule // op_timer

// *** hw/idle_regulator.v ***
// flash regulator standby and wake-up delay during cpu idle
`timescale 1ns/1ps
`include "flash_op_map.vh"
module idle_regulator #(
  parameter WAKE_CYCLES = `FOC_WAKE_CYC
) (
  // clock and reset
  input  wire sys_clk,
  input  wire sys_rst,
  // control
  input  wire standby_en,
  input  wire idle_sync,
  // status
  output wire reg_standby,
  output wire flash_ready
);

  // wake count cut to the 16-bit counter on purpose
  localparam [31:0] WAKE_FULL = WAKE_CYCLES;
  localparam [15:0] WAKE      = WAKE_FULL[15:0];

  reg        sb_q;   // regulator in standby
  reg [15:0] wake_q; // wake cycles left

  // ************************************
  // standby and wake tracking
  // ************************************
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      sb_q   <= 1'b0;
      wake_q <= 16'h0000;
    end else begin
      if (idle_sync && standby_en) begin
        sb_q   <= 1'b1;
        wake_q <= 16'h0000;
      end else if (sb_q) begin
        sb_q   <= 1'b0;
        wake_q <= WAKE;
      end else if (wake_q != 16'h0000) begin
        wake_q <= wake_q - 16'h0001;
      end
    end
  end

  assign reg_standby = sb_q;
  assign flash_ready = !sb_q && (wake_q == 16'h0000);

endmodule // idle_regulator

// *** hw/flash_operation_control.v ***
// axi4-lite control registers and sequencer for flash program and erase
`timescale 1ns/1ps
`include "flash_op_map.vh"
module flash_operation_control #(
  parameter ERASE_CYCLES = `FOC_ERASE_CYC,
  parameter PROG_CYCLES  = `FOC_PROG_CYC,
  parameter WAKE_CYCLES  = `FOC_WAKE_CYC
) (
  // clock and resets
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        por_rst,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // cpu power state
  input  wire        cpu_idle,
  input  wire        power_save_instruction,
  output wire        power_save_accept,
  // flash array
  output reg         page_erase_strobe,
  output reg         dword_prog_strobe,
  output reg  [23:0] flash_addr,
  output wire        flash_busy,
  output wire        regulator_standby,
  output wire        flash_ready
);

  // ************************************
  // state encoding
  // ************************************
  localparam [1:0] ST_IDLE = 2'd0; // waiting for start
  localparam [1:0] ST_WAKE = 2'd1; // waiting for regulator
  localparam [1:0] ST_RUN  = 2'd2; // timed operation

  // counts cut to the 24-bit timer on purpose
  localparam [31:0] ERASE_FULL = ERASE_CYCLES;
  localparam [31:0] PROG_FULL  = PROG_CYCLES;
  localparam [23:0] ERASE_CNT  = ERASE_FULL[23:0];
  localparam [23:0] PROG_CNT   = PROG_FULL[23:0];

  // ************************************
  // register state
  // ************************************
  reg        start_q;     // launch bit
  reg        enable_q;    // write enable
  reg        error_q;     // bad sequence flag
  reg        idle_sb_q;   // regulator standby in idle
  reg [3:0]  opsel_q;     // operation select
  reg [23:0] addr_q;      // target address
  reg [1:0]  state_q;     // sequencer state
  reg [1:0]  state_d;
  reg        aw_held_q;   // write address latched
  reg        w_held_q;    // write data latched
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg        idle_m_q;    // idle synchroniser stage 1
  reg        idle_s_q;    // idle synchroniser stage 2
  reg        launch_q;    // one-cycle timer load
  reg [23:0] load_cnt_q;

  wire       tmr_busy;
  wire       tmr_done;
  wire       op_valid;
  wire [3:0] opsel_new;   // select that a start will use
  wire       wr_fire;
  wire       ctrl_wr;
  wire       start_set;
  wire [15:0] ctrl_rd;

  // only two codes do anything
  // a start judges the select written alongside it, not the stale one
  assign opsel_new = (ctrl_wr && wstrb_q[0] && !start_q) ? wdata_q[`FOC_OPSEL_HI:`FOC_OPSEL_LO] : opsel_q;
  assign op_valid  = (opsel_new == `FOC_OP_PAGE_ERASE) || (opsel_new == `FOC_OP_DWORD_PROG);

  // ************************************
  // axi write channel capture
  // ************************************
  // address and data accepted in either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
  assign ctrl_wr       = wr_fire && (awaddr_q == `FOC_CTRL_OFS);
  assign start_set     = ctrl_wr && wstrb_q[1] && wdata_q[`FOC_START_BIT];

  // latch each channel, respond once both are held
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= 12'h000;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped offsets answer slverr
        if (awaddr_q == `FOC_CTRL_OFS || awaddr_q == `FOC_ADDR_OFS ||
            awaddr_q == `FOC_STAT_OFS) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************
  // power-on fields
  // ************************************
  // select cleared only by power-on reset
  always @(posedge sys_clk) begin
    if (por_rst) begin
      opsel_q <= 4'h0;
    end else if (ctrl_wr && wstrb_q[0] && !start_q) begin
      // locked while an operation runs
      opsel_q <= wdata_q[`FOC_OPSEL_HI:`FOC_OPSEL_LO];
    end
  end

  // ************************************
  // control bits and address
  // ************************************
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      enable_q  <= 1'b0;
      error_q   <= 1'b0;
      idle_sb_q <= 1'b0;
      addr_q    <= 24'h000000;
      start_q   <= 1'b0;
    end else begin
      if (ctrl_wr && wstrb_q[1]) begin
        enable_q  <= wdata_q[`FOC_ENABLE_BIT];
        idle_sb_q <= wdata_q[`FOC_IDLE_SB_BIT];
        // software may only clear the error flag
        if (!wdata_q[`FOC_ERROR_BIT]) begin
          error_q <= 1'b0;
        end
      end
      if (wr_fire && awaddr_q == `FOC_ADDR_OFS && !start_q) begin
        addr_q <= wdata_q[23:0];
      end
      if (start_set && !start_q) begin
        // enable counts from the same write as start
        if (wdata_q[`FOC_ENABLE_BIT] && op_valid) begin
          start_q <= 1'b1;
        end else begin
          // set wins over any same-cycle clear
          error_q <= 1'b1;
        end
      end else if (tmr_done) begin
        start_q <= 1'b0;
      end
    end
  end

  // ************************************
  // idle synchroniser
  // ************************************
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      idle_m_q <= 1'b0;
      idle_s_q <= 1'b0;
    end else begin
      idle_m_q <= cpu_idle;
      idle_s_q <= idle_m_q;
    end
  end

  // ************************************
  // sequencer next state
  // ************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_q && !tmr_busy && !launch_q) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (flash_ready) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (tmr_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ************************************
  // sequencer registers and strobes
  // ************************************
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q           <= ST_IDLE;
      launch_q          <= 1'b0;
      load_cnt_q        <= 24'h000000;
      page_erase_strobe <= 1'b0;
      dword_prog_strobe <= 1'b0;
      flash_addr        <= 24'h000000;
    end else begin
      state_q           <= state_d;
      launch_q          <= 1'b0;
      page_erase_strobe <= 1'b0;
      dword_prog_strobe <= 1'b0;
      if (state_q == ST_WAKE && flash_ready) begin
        launch_q <= 1'b1;
        if (opsel_q == `FOC_OP_PAGE_ERASE) begin
          page_erase_strobe <= 1'b1;
          load_cnt_q        <= ERASE_CNT;
          flash_addr        <= addr_q;
        end else begin
          dword_prog_strobe <= 1'b1;
          load_cnt_q        <= PROG_CNT;
          flash_addr        <= {addr_q[23:2], 2'b00};
        end
      end
    end
  end

  // ************************************
  // helpers
  // ************************************
  op_timer #(
    .WIDTH (24)
  ) u_timer (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .load    (launch_q),
    .count   (load_cnt_q),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  idle_regulator #(
    .WAKE_CYCLES (WAKE_CYCLES)
  ) u_reg (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .standby_en  (idle_sb_q),
    .idle_sync   (idle_s_q),
    .reg_standby (regulator_standby),
    .flash_ready (flash_ready)
  );

  assign flash_busy = start_q;

  assign power_save_accept = power_save_instruction && !start_q;

  // ************************************
  // axi read channel
  // ************************************
  // bits 11-4 read as zero
  assign ctrl_rd = {start_q, enable_q, error_q, idle_sb_q, 8'h00, opsel_q};
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `FOC_CTRL_OFS: s_axi_rdata <= {16'h0000, ctrl_rd};
        `FOC_STAT_OFS: s_axi_rdata <= {26'h0000000, flash_ready, regulator_standby,
                                       tmr_busy, state_q, start_q};
        `FOC_ADDR_OFS: s_axi_rdata <= {8'h00, addr_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // flash_operation_control

// *** sim/flash_array_model.sv ***
// behavioural flash array that counts launches
`timescale 1ns/1ps
module flash_array_model (
  // clock
  input  wire         sys_clk,
  // launch strobes from the block
  input  wire         page_erase_strobe,
  input  wire         dword_prog_strobe,
  input  wire  [23:0] flash_addr,
  // observation for the bench
  output logic [31:0] erase_count,
  output logic [31:0] prog_count,
  output logic [23:0] last_addr
);
  // counters start clear, no reset pin on the array
  initial begin
    erase_count = 32'h0;
    prog_count = 32'h0;
    last_addr = 24'h0;
  end
  always @(posedge sys_clk) begin
    if (page_erase_strobe) erase_count <= erase_count + 32'h1;
  end
  always @(posedge sys_clk) begin
    if (dword_prog_strobe) begin
      prog_count <= prog_count + 32'h1;
      last_addr <= flash_addr;
    end
  end
endmodule // flash_array_model

// *** sim/flash_operation_control_chk.sv ***
// assertion checker for the flash operation control block
`timescale 1ns/1ps
module flash_operation_control_chk (
  // clock and resets
  input wire        sys_clk,
  input wire        sys_rst,
  input wire        por_rst,
  // power state
  input wire        power_save_instruction,
  input wire        power_save_accept,
  // flash side
  input wire        page_erase_strobe,
  input wire        dword_prog_strobe,
  input wire [23:0] flash_addr,
  input wire        flash_busy,
  input wire        regulator_standby,
  input wire        flash_ready
);
  // either reset silences the checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || por_rst);
  AST_PS_REFUSE: assert property (power_save_accept == (power_save_instruction & !flash_busy))
    else $error("power save accept wrong");
  AST_ERASE_PULSE: assert property (page_erase_strobe |=> !page_erase_strobe)
    else $error("erase strobe too long");
  AST_PROG_PULSE: assert property (dword_prog_strobe |=> !dword_prog_strobe)
    else $error("program strobe too long");
  AST_PROG_ALIGN: assert property (dword_prog_strobe |-> flash_addr[1:0] == 2'h0)
    else $error("program address unaligned");
  AST_LAUNCH_BUSY: assert property ((page_erase_strobe || dword_prog_strobe) |-> flash_busy)
    else $error("launch without busy");
  AST_PROG_HOLD: assert property (dword_prog_strobe |=> flash_busy [*4])
    else $error("program ended early");
  AST_PROG_END: assert property (dword_prog_strobe |-> ##[1:600] !flash_busy)
    else $error("program never ended");
  // no launch on a sleeping regulator
  AST_LAUNCH_READY: assert property ((page_erase_strobe || dword_prog_strobe) |-> flash_ready)
    else $error("launch while regulator not ready");
  AST_STANDBY_READY: assert property (regulator_standby |-> !flash_ready)
    else $error("ready during standby");
  AST_WAKE_DELAY: assert property ($fell(regulator_standby) |-> !flash_ready [*3])
    else $error("wake delay skipped");
endmodule // flash_operation_control_chk

bind flash_operation_control flash_operation_control_chk chk_u (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .por_rst(por_rst),
  .power_save_instruction(power_save_instruction), .power_save_accept(power_save_accept),
  .page_erase_strobe(page_erase_strobe), .dword_prog_strobe(dword_prog_strobe),
  .flash_addr(flash_addr), .flash_busy(flash_busy),
  .regulator_standby(regulator_standby), .flash_ready(flash_ready));

// *** sim/test_flash_operation_control.sv ***
// self-checking bench for the flash operation control block
`timescale 1ns/1ps
module test_flash_operation_control;
  // ****************
  // pins and bench state
  // ****************
  logic        sys_clk = 1'h0, sys_rst = 1'h1, por_rst = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1; // always ready for answers
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        cpu_idle = 1'h0, power_save_instruction = 1'h0, power_save_accept;
  logic        page_erase_strobe, dword_prog_strobe, flash_busy, regulator_standby, flash_ready;
  logic [23:0] flash_addr, last_addr;
  logic [31:0] erase_count, prog_count, rd, n_mismatch = 32'h0, tests_run = 32'h0;
  integer      i;

  // short counts keep the run brief
  flash_operation_control #(.ERASE_CYCLES(20), .PROG_CYCLES(5), .WAKE_CYCLES(4)) dut_u (
    .sys_clk, .sys_rst, .por_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_idle, .power_save_instruction, .power_save_accept,
    .page_erase_strobe, .dword_prog_strobe, .flash_addr, .flash_busy, .regulator_standby,
    .flash_ready);
  flash_array_model mdl_u (.sys_clk, .page_erase_strobe, .dword_prog_strobe, .flash_addr,
    .erase_count, .prog_count, .last_addr);

  // 100 ns period
  always #50 sys_clk = ~sys_clk;

  // ****************
  // report and bus tasks
  // ****************
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // a bounded wait ran out
  task automatic hang;
    n_mismatch++;
    $display("unexpected wait expected answer seen timeout");
    results;
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) hang;
    resp = s_axi_bresp;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) hang;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // poll status until the start bit drops
  task automatic wait_idle;
    int n;
    for (n = 0; n < 200; n++) begin
      rd_reg(12'h004);
      if (rd[0] === 1'h0) break;
    end
    if (n == 200) hang;
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'h0;
    por_rst <= 1'h0;
    @(posedge sys_clk);
    rd_reg(12'h000);
    chk("ctrl reset", 32'h0, rd);
    wr(12'h000, 32'h0ff1);
    chk("ctrl write resp", 32'h0, {30'h0, resp});
    rd_reg(12'h000);
    chk("ctrl gap bits", 32'h1, rd);
    rd_reg(12'h0f0);
    chk("unmapped resp", 32'h2, {30'h0, resp});
    chk("unmapped data", 32'h0, rd);
    wr(12'h0f0, 32'hffff);
    chk("unmapped wr resp", 32'h2, {30'h0, resp});
    $display("test registers done");
    // erase with a power-save request pending
    wr(12'h000, 32'hc003);
    power_save_instruction <= 1'h1;
    repeat (3) @(posedge sys_clk);
    chk("accept busy", 32'h0, {31'h0, power_save_accept});
    wait_idle;
    chk("accept idle", 32'h1, {31'h0, power_save_accept});
    power_save_instruction <= 1'h0;
    chk("erase count", 32'h1, erase_count);
    rd_reg(12'h000);
    chk("ctrl after erase", 32'h3, rd & 32'h800f);
    $display("test erase done");
    // unaligned address lands on the four-byte boundary
    wr(12'h008, 32'h123);
    wr(12'h000, 32'hc001);
    wait_idle;
    chk("prog count", 32'h1, prog_count);
    chk("prog addr", 32'h120, {8'h0, last_addr});
    $display("test program done");
    // every reserved code refused
    for (i = 0; i < 16; i++) begin
      if (i == 1 || i == 3) continue;
      wr(12'h000, 32'hc000 | i);
      rd_reg(12'h000);
      chk("reserved error", 32'h2000, rd & 32'ha000);
      wr(12'h000, 32'h0);
    end
    // start without enable refused
    wr(12'h000, 32'h8003);
    rd_reg(12'h000);
    chk("enable off error", 32'h2000, rd & 32'ha000);
    wr(12'h000, 32'h0);
    wait_idle;
    chk("erase total", 32'h1, erase_count);
    chk("prog total", 32'h1, prog_count);
    $display("test reserved done");
    // standby in idle, launch waits for wake
    wr(12'h000, 32'h1000);
    cpu_idle <= 1'h1;
    repeat (4) @(posedge sys_clk);
    chk("standby on", 32'h1, {31'h0, regulator_standby});
    chk("ready off", 32'h0, {31'h0, flash_ready});
    wr(12'h000, 32'hd001);
    repeat (8) @(posedge sys_clk);
    chk("no prog in idle", 32'h1, prog_count);
    cpu_idle <= 1'h0;
    wait_idle;
    chk("prog after wake", 32'h2, prog_count);
    wr(12'h000, 32'h0);
    cpu_idle <= 1'h1;
    repeat (4) @(posedge sys_clk);
    chk("standby off", 32'h0, {31'h0, regulator_standby});
    cpu_idle <= 1'h0;
    $display("test idle done");
    // only power-on reset clears the select field
    wr(12'h000, 32'h3);
    sys_rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    rd_reg(12'h000);
    chk("opsel kept", 32'h3, rd & 32'hf);
    por_rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    por_rst <= 1'h0;
    @(posedge sys_clk);
    rd_reg(12'h000);
    chk("opsel por", 32'h0, rd & 32'hf);
    $display("test reset done");
    results;
  end
endmodule // test_flash_operation_control
